// ===== design/led_regs_pkg.sv
package led_regs_pkg;
	// serial management addresses, 8-bit register pointer space
	localparam logic [7:0] ADDR_ENABLE_HIGH   = 8'h00;
	localparam logic [7:0] ADDR_ENABLE_LOW    = 8'h01;
	localparam logic [7:0] ADDR_PERIOD_HIGH   = 8'h02;
	localparam logic [7:0] ADDR_PERIOD_LOW    = 8'h03;
	localparam logic [7:0] ADDR_TRIP_CODE     = 8'h04;
	localparam logic [7:0] ADDR_GND_SHORT     = 8'h35;
	localparam logic [7:0] ADDR_STR_SHORT     = 8'h37;
	localparam logic [7:0] ADDR_HELD_FAULT_HI = 8'h38;
	localparam logic [7:0] ADDR_HELD_FAULT_LO = 8'h39;
	localparam logic [7:0] ADDR_HELD_REG      = 8'h3B;
	localparam logic [7:0] ADDR_HELD_GND      = 8'h3D;
	localparam logic [7:0] ADDR_HELD_STR      = 8'h3F;
	localparam logic [7:0] ADDR_DRIVE_OK      = 8'h41;
	localparam logic [7:0] ADDR_HELD_DRIVE_OK = 8'h43;

	// reset values
	localparam logic [7:0]  RST_ENABLE_HIGH = 8'h03;
	localparam logic [7:0]  RST_ENABLE_LOW  = 8'hFF;
	localparam logic [12:0] RST_PERIOD      = 13'h0FFF;
	localparam logic [4:0]  RST_TRIP_CODE   = 5'h1C;

	// field widths
	localparam int PERIOD_HIGH_BITS = 5;
	localparam int HELD_FAULT_HI_W  = 4;

	// overvoltage trip: base volts plus one volt per code step
	localparam logic [5:0] TRIP_BASE_VOLTS = 6'h08;

	// dimming step and on-time ceiling
	localparam longint CLK_PERIOD_PS    = 5000;
	localparam longint STEP_TIME_PS     = 1500000;
	localparam longint ONTIME_MAX_US    = 9830;
	localparam longint STEP_CYCLES_L    = STEP_TIME_PS / CLK_PERIOD_PS;
	localparam longint ONTIME_STEPS_L   = (ONTIME_MAX_US * 64'd1000000) / STEP_TIME_PS;
	localparam logic [8:0]  STEP_CYCLES    = STEP_CYCLES_L[8:0];
	localparam logic [13:0] ONTIME_MAX_STEPS = ONTIME_STEPS_L[13:0];

	// bus framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT      = 4'h7;

	typedef enum logic [2:0] {
		ST_IDLE, ST_RECV, ST_SLAVE_ACK, ST_SEND, ST_MASTER_ACK
	} bus_state_t;

	// fault and status inputs from the analog sense logic
	typedef struct packed {
		logic [11:0] general;
		logic [7:0]  regulation_loss;
		logic [7:0]  ground_short;
		logic [7:0]  string_short;
		logic [7:0]  drive_ok;
		logic [7:0]  unpopulated;
	} fault_in_t;

	// settings handed to the boost and sink logic
	typedef struct packed {
		logic [7:0]  string_enable_byte;
		logic [12:0] pwm_period;
		logic [4:0]  overvoltage_code;
		logic [5:0]  overvoltage_volts;
		logic [13:0] on_time_limit;
	} config_out_t;
endpackage

// ===== design/led_driver_status_config_regs.sv
`timescale 1ns/1ps
// Function
// (RL1) enable byte bits switch strings, all on
// (RL2) host clears upper enable register to zero
// (RL3) enabled unpopulated string at startup halts, flags
// (RL4) host clears fault 11 by writing 0x0400
// (RL5) held faults latch until host write clears
// (RL6) live short status per string, read only
// (RL7) period is (N+1) steps of 1.5 us
// (RL8) period field resets to 0x0fff
// (RL9) on-time limited to 9.830 ms
// (RL10) host keeps period code within recommended range
// (RL11) trip point is 8 V plus code volts
// (RL12) overvoltage code resets to 0x1C
// (RL13) high byte first, reserved bits read zero
module led_driver_status_config_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// serial management pins, open drain
	input  wire logic                       scl_in,
	input  wire logic                       sda_in,
	output logic                            sda_out,
	output logic                            sda_oe,
	// analog sense and startup
	input  wire led_regs_pkg::fault_in_t    fault_in,
	input  wire logic                       startup_active,
	// settings and flags
	output led_regs_pkg::config_out_t       cfg_out,
	output logic                            fault_n,
	output logic                            startup_halt,
	output logic                            pwm_period_start
);
	led_regs_pkg::bus_state_t state_reg;
	logic        scl_q_reg, sda_q_reg, scl_prev_reg, sda_prev_reg;
	logic [3:0]  cnt_reg;
	logic [7:0]  rx_reg, tx_reg, ptr_reg;
	logic        addr_phase_reg, ptr_phase_reg, read_reg, mack_ok_reg, sda_out_reg;
	logic        wr_stb_reg;
	logic [7:0]  wr_addr_reg, wr_data_reg;
	logic [7:0]  enable_high_reg, enable_low_reg, period_low_reg;
	logic [4:0]  period_high_reg, trip_code_reg;
	logic [7:0]  gnd_live_reg, str_live_reg, drive_live_reg;
	logic [11:0] held_fault_reg, held_fault_next;
	logic [7:0]  held_reg_reg, held_gnd_reg, held_str_reg, held_drv_reg;
	logic [7:0]  held_reg_next, held_gnd_next, held_str_next, held_drv_next;
	logic        fault_n_reg, halt_reg, tick_reg;
	logic [8:0]  presc_reg;
	logic [12:0] step_reg;
	logic [7:0]  rd_data;
	logic        scl_rise, scl_fall, bus_start, bus_stop;
	logic [12:0] period_n;

	assign scl_rise  = scl_q_reg & ~scl_prev_reg;
	assign scl_fall  = ~scl_q_reg & scl_prev_reg;
	assign bus_start = scl_q_reg & scl_prev_reg & sda_prev_reg & ~sda_q_reg;
	assign bus_stop  = scl_q_reg & scl_prev_reg & ~sda_prev_reg & sda_q_reg;
	assign period_n  = {period_high_reg, period_low_reg}; // see (RL7)

	// pin sampling, inputs are already synchronous
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_q_reg    <= 1'b1;
			sda_q_reg    <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_q_reg    <= scl_in;
			sda_q_reg    <= sda_in;
			scl_prev_reg <= scl_q_reg;
			sda_prev_reg <= sda_q_reg;
		end
	end

	// read mux; reserved and unmapped addresses return zero
	always_comb begin
		if (ptr_reg == led_regs_pkg::ADDR_ENABLE_HIGH) begin
			rd_data = enable_high_reg;
		end else if (ptr_reg == led_regs_pkg::ADDR_ENABLE_LOW) begin
			rd_data = enable_low_reg;
		end else if (ptr_reg == led_regs_pkg::ADDR_PERIOD_HIGH) begin
			rd_data = {3'h0, period_high_reg}; // see (RL13)
		end else if (ptr_reg == led_regs_pkg::ADDR_PERIOD_LOW) begin
			rd_data = period_low_reg;
		end else if (ptr_reg == led_regs_pkg::ADDR_TRIP_CODE) begin
			rd_data = {3'h0, trip_code_reg};
		end else if (ptr_reg == led_regs_pkg::ADDR_GND_SHORT) begin
			rd_data = gnd_live_reg; // see (RL6)
		end else if (ptr_reg == led_regs_pkg::ADDR_STR_SHORT) begin
			rd_data = str_live_reg;
		end else if (ptr_reg == led_regs_pkg::ADDR_HELD_FAULT_HI) begin
			rd_data = {4'h0, held_fault_reg[11:8]}; // see (RL13)
		end else if (ptr_reg == led_regs_pkg::ADDR_HELD_FAULT_LO) begin
			rd_data = held_fault_reg[7:0];
		end else if (ptr_reg == led_regs_pkg::ADDR_HELD_REG) begin
			rd_data = held_reg_reg;
		end else if (ptr_reg == led_regs_pkg::ADDR_HELD_GND) begin
			rd_data = held_gnd_reg;
		end else if (ptr_reg == led_regs_pkg::ADDR_HELD_STR) begin
			rd_data = held_str_reg;
		end else if (ptr_reg == led_regs_pkg::ADDR_DRIVE_OK) begin
			rd_data = drive_live_reg;
		end else if (ptr_reg == led_regs_pkg::ADDR_HELD_DRIVE_OK) begin
			rd_data = held_drv_reg;
		end else begin
			rd_data = 8'h00;
		end
	end

	// bus engine: address, pointer byte, then data with auto-increment
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg      <= led_regs_pkg::ST_IDLE;
			cnt_reg        <= 4'h0;
			rx_reg         <= 8'h00;
			tx_reg         <= 8'h00;
			ptr_reg        <= 8'h00;
			addr_phase_reg <= 1'b0;
			ptr_phase_reg  <= 1'b0;
			read_reg       <= 1'b0;
			mack_ok_reg    <= 1'b0;
			sda_oe         <= 1'b0;
			wr_stb_reg     <= 1'b0;
			wr_addr_reg    <= 8'h00;
			wr_data_reg    <= 8'h00;
		end else begin
			wr_stb_reg <= 1'b0;
			if (bus_start) begin
				state_reg      <= led_regs_pkg::ST_RECV;
				cnt_reg        <= 4'h0;
				addr_phase_reg <= 1'b1;
				sda_oe         <= 1'b0;
			end else if (bus_stop) begin
				state_reg <= led_regs_pkg::ST_IDLE;
				sda_oe    <= 1'b0;
			end else begin
				case (state_reg)
					led_regs_pkg::ST_RECV: begin
						if (scl_rise) begin
							rx_reg  <= {rx_reg[6:0], sda_q_reg};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall && cnt_reg == led_regs_pkg::BITS_PER_BYTE) begin
							state_reg <= led_regs_pkg::ST_SLAVE_ACK;
							sda_oe    <= 1'b1;
							if (addr_phase_reg) begin
								addr_phase_reg <= 1'b0;
								read_reg       <= rx_reg[0];
								ptr_phase_reg  <= ~rx_reg[0];
								if (rx_reg[7:1] != DEV_ADDR) begin
									state_reg <= led_regs_pkg::ST_IDLE; // not ours
									sda_oe    <= 1'b0;
								end
							end else if (ptr_phase_reg) begin
								ptr_reg       <= rx_reg;
								ptr_phase_reg <= 1'b0;
							end else begin
								wr_stb_reg  <= 1'b1;
								wr_addr_reg <= ptr_reg;
								wr_data_reg <= rx_reg;
								ptr_reg     <= ptr_reg + 8'h01; // see (RL13)
							end
						end
					end
					led_regs_pkg::ST_SLAVE_ACK: begin
						if (scl_fall) begin
							cnt_reg <= 4'h0;
							if (read_reg) begin
								state_reg <= led_regs_pkg::ST_SEND;
								tx_reg    <= rd_data;
								sda_oe    <= ~rd_data[7];
							end else begin
								state_reg <= led_regs_pkg::ST_RECV;
								sda_oe    <= 1'b0;
							end
						end
					end
					led_regs_pkg::ST_SEND: begin
						if (scl_fall) begin
							cnt_reg <= cnt_reg + 4'h1;
							if (cnt_reg == led_regs_pkg::LAST_BIT) begin
								state_reg <= led_regs_pkg::ST_MASTER_ACK;
								sda_oe    <= 1'b0;
								ptr_reg   <= ptr_reg + 8'h01;
							end else begin
								tx_reg <= {tx_reg[6:0], 1'b0};
								sda_oe <= ~tx_reg[6];
							end
						end
					end
					led_regs_pkg::ST_MASTER_ACK: begin
						if (scl_rise) begin
							mack_ok_reg <= ~sda_q_reg;
							if (sda_q_reg) begin
								state_reg <= led_regs_pkg::ST_IDLE; // host said no more
							end
						end else if (scl_fall && mack_ok_reg) begin
							state_reg <= led_regs_pkg::ST_SEND;
							cnt_reg   <= 4'h0;
							tx_reg    <= rd_data;
							sda_oe    <= ~rd_data[7];
						end
					end
					default: begin
						state_reg <= led_regs_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// open drain only ever pulls low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
		end
	end
	assign sda_out = sda_out_reg;

	// configuration registers; upper enable byte resets to an odd value until the host writes it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_high_reg <= led_regs_pkg::RST_ENABLE_HIGH; // see (RL2)
			enable_low_reg  <= led_regs_pkg::RST_ENABLE_LOW; // see (RL1)
			period_high_reg <= led_regs_pkg::RST_PERIOD[12:8]; // see (RL8)
			period_low_reg  <= led_regs_pkg::RST_PERIOD[7:0];
			trip_code_reg   <= led_regs_pkg::RST_TRIP_CODE; // see (RL12)
		end else if (wr_stb_reg) begin
			if (wr_addr_reg == led_regs_pkg::ADDR_ENABLE_HIGH) begin
				enable_high_reg <= wr_data_reg;
			end else if (wr_addr_reg == led_regs_pkg::ADDR_ENABLE_LOW) begin
				enable_low_reg <= wr_data_reg; // see (RL1)
			end else if (wr_addr_reg == led_regs_pkg::ADDR_PERIOD_HIGH) begin
				period_high_reg <= wr_data_reg[led_regs_pkg::PERIOD_HIGH_BITS-1:0];
			end else if (wr_addr_reg == led_regs_pkg::ADDR_PERIOD_LOW) begin
				period_low_reg <= wr_data_reg;
			end else if (wr_addr_reg == led_regs_pkg::ADDR_TRIP_CODE) begin
				trip_code_reg <= wr_data_reg[4:0];
			end
		end
	end

	// live status, a snapshot of the sense inputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gnd_live_reg   <= 8'h00;
			str_live_reg   <= 8'h00;
			drive_live_reg <= 8'h00;
		end else begin
			gnd_live_reg   <= fault_in.ground_short; // see (RL6)
			str_live_reg   <= fault_in.string_short;
			drive_live_reg <= fault_in.drive_ok;
		end
	end

	// held faults: a new event wins over a clear in the same cycle
	always_comb begin
		held_fault_next = held_fault_reg;
		held_reg_next   = held_reg_reg;
		held_gnd_next   = held_gnd_reg;
		held_str_next   = held_str_reg;
		held_drv_next   = held_drv_reg;
		if (wr_stb_reg) begin
			if (wr_addr_reg == led_regs_pkg::ADDR_HELD_FAULT_HI) begin
				held_fault_next[11:8] = held_fault_reg[11:8]
					& ~wr_data_reg[led_regs_pkg::HELD_FAULT_HI_W-1:0]; // see (RL4)
			end else if (wr_addr_reg == led_regs_pkg::ADDR_HELD_FAULT_LO) begin
				held_fault_next[7:0] = held_fault_reg[7:0] & ~wr_data_reg;
			end else if (wr_addr_reg == led_regs_pkg::ADDR_HELD_REG) begin
				held_reg_next = held_reg_reg & ~wr_data_reg;
			end else if (wr_addr_reg == led_regs_pkg::ADDR_HELD_GND) begin
				held_gnd_next = held_gnd_reg & ~wr_data_reg;
			end else if (wr_addr_reg == led_regs_pkg::ADDR_HELD_STR) begin
				held_str_next = held_str_reg & ~wr_data_reg;
			end else if (wr_addr_reg == led_regs_pkg::ADDR_HELD_DRIVE_OK) begin
				held_drv_next = held_drv_reg & ~wr_data_reg;
			end
		end
		held_fault_next = held_fault_next | fault_in.general; // see (RL5)
		held_reg_next   = held_reg_next | fault_in.regulation_loss;
		held_gnd_next   = held_gnd_next | fault_in.ground_short;
		held_str_next   = held_str_next | fault_in.string_short;
		held_drv_next   = held_drv_next | ~fault_in.drive_ok;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held_fault_reg <= 12'h000;
			held_reg_reg   <= 8'h00;
			held_gnd_reg   <= 8'h00;
			held_str_reg   <= 8'h00;
			held_drv_reg   <= 8'h00;
		end else begin
			held_fault_reg <= held_fault_next; // see (RL5)
			held_reg_reg   <= held_reg_next;
			held_gnd_reg   <= held_gnd_next;
			held_str_reg   <= held_str_next;
			held_drv_reg   <= held_drv_next;
		end
	end

	// startup check; halt is sticky so startup cannot slip past the error
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_n_reg <= 1'b1;
			halt_reg    <= 1'b0;
		end else begin
			fault_n_reg <= ~(startup_active && |(fault_in.unpopulated & enable_low_reg)); // see (RL3)
			if (startup_active && |(fault_in.unpopulated & enable_low_reg)) begin
				halt_reg <= 1'b1; // see (RL3)
			end else if (!startup_active) begin
				halt_reg <= 1'b0;
			end
		end
	end
	assign fault_n      = fault_n_reg;
	assign startup_halt = halt_reg;

	// dimming period timer: prescaler wraps once per step, one tick per period of N+1 steps
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presc_reg <= 9'h000;
			step_reg  <= 13'h0000;
			tick_reg  <= 1'b0;
		end else begin
			tick_reg <= 1'b0;
			if (presc_reg == led_regs_pkg::STEP_CYCLES - 9'h001) begin
				presc_reg <= 9'h000;
				if (step_reg >= period_n) begin
					step_reg <= 13'h0000; // see (RL7)
					tick_reg <= 1'b1;
				end else begin
					step_reg <= step_reg + 13'h0001;
				end
			end else begin
				presc_reg <= presc_reg + 9'h001;
			end
		end
	end
	assign pwm_period_start = tick_reg;

	// settings out, with derived trip volts and the on-time ceiling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_out <= '0;
		end else begin
			cfg_out.string_enable_byte <= enable_low_reg; // see (RL1)
			cfg_out.pwm_period         <= period_n;
			cfg_out.overvoltage_code   <= trip_code_reg;
			cfg_out.overvoltage_volts  <= led_regs_pkg::TRIP_BASE_VOLTS
				+ {1'b0, trip_code_reg}; // see (RL11)
			cfg_out.on_time_limit      <= ({1'b0, period_n} + 14'h0001
				> led_regs_pkg::ONTIME_MAX_STEPS) ? led_regs_pkg::ONTIME_MAX_STEPS
				: {1'b0, period_n} + 14'h0001; // see (RL9)
		end
	end

	property p_enable_write;
		@(posedge clk) disable iff (rst)
		(wr_stb_reg && wr_addr_reg == led_regs_pkg::ADDR_ENABLE_LOW)
			|=> ##1 cfg_out.string_enable_byte == $past(wr_data_reg, 2);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable byte not applied"); // see (RL1)

	property p_fault_flag;
		@(posedge clk) disable iff (rst)
		(startup_active && |(fault_in.unpopulated & enable_low_reg)) |=> !fault_n && startup_halt;
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("fault flag not raised"); // see (RL3)

	property p_held_set;
		@(posedge clk) disable iff (rst)
		fault_in.general != 12'h000
			|=> (held_fault_reg & $past(fault_in.general)) == $past(fault_in.general);
	endproperty
	a_held_set: assert property (p_held_set) else $error("general fault not held"); // see (RL5)

	property p_held_keep;
		@(posedge clk) disable iff (rst)
		!wr_stb_reg |=> (held_gnd_reg & $past(held_gnd_reg)) == $past(held_gnd_reg);
	endproperty
	a_held_keep: assert property (p_held_keep) else $error("held bit lost without write"); // see (RL5)

	property p_live;
		@(posedge clk) disable iff (rst)
		1'b1 |=> str_live_reg == $past(fault_in.string_short);
	endproperty
	a_live: assert property (p_live) else $error("live status stale"); // see (RL6)

	property p_period_tick;
		@(posedge clk) disable iff (rst)
		tick_reg |-> step_reg == 13'h0000 && presc_reg == 9'h000;
	endproperty
	a_period_tick: assert property (p_period_tick) else $error("period tick misplaced"); // see (RL7)

	property p_ontime_cap;
		@(posedge clk) disable iff (rst)
		1'b1 |=> cfg_out.on_time_limit <= led_regs_pkg::ONTIME_MAX_STEPS;
	endproperty
	a_ontime_cap: assert property (p_ontime_cap) else $error("on-time beyond ceiling"); // see (RL9)

	// volts lag the code by one register stage
	property p_trip_volts;
		@(posedge clk) disable iff (rst)
		1'b1 |=> cfg_out.overvoltage_volts == {1'b0, $past(trip_code_reg)} + 6'h08;
	endproperty
	a_trip_volts: assert property (p_trip_volts) else $error("trip volts wrong"); // see (RL11)

	property p_reserved_zero;
		@(posedge clk) disable iff (rst)
		ptr_reg == led_regs_pkg::ADDR_PERIOD_HIGH |-> rd_data[7:5] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // see (RL13)
endmodule

// ===== bench/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
	// clock
	input  wire logic clk,
	// bus pins, host side
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	// acks the device left out, read by the bench at the end
	int nacks = 0;

	// bus idles released, clock high
	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	// one bus phase, kept above the 4 clk minimum
	task automatic phase();
		repeat (5) @(negedge clk);
	endtask

	// data moves one clk after scl falls, so it is never mistaken for a start or stop
	task automatic put_bit(input logic b);
		@(negedge clk);
		sda_pull = ~b;
		phase();
		scl = 1'b1;
		phase();
		scl = 1'b0;
	endtask

	task automatic get_bit(output logic b);
		@(negedge clk);
		sda_pull = 1'b0;
		phase();
		scl = 1'b1;
		repeat (3) @(negedge clk);
		b = sda;
		repeat (2) @(negedge clk);
		scl = 1'b0;
	endtask

	// start works both from idle and as a repeated start
	task automatic start();
		@(negedge clk);
		sda_pull = 1'b0;
		phase();
		scl = 1'b1;
		phase();
		sda_pull = 1'b1;
		phase();
		scl = 1'b0;
	endtask

	task automatic stop();
		@(negedge clk);
		sda_pull = 1'b1;
		phase();
		scl = 1'b1;
		phase();
		sda_pull = 1'b0;
		phase();
	endtask

	task automatic send_byte(input logic [7:0] v);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			put_bit(v[i]);
		end
		get_bit(b);
		if (b) begin
			nacks++;
		end
	endtask

	// n bytes from consecutive addresses, lowest address first
	task automatic write_regs(input logic [7:0] ptr, input logic [31:0] d, input int n);
		start();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(ptr);
		for (int k = 0; k < n; k++) begin
			send_byte(d[8*(n-1-k) +: 8]);
		end
		stop();
	endtask

	task automatic read_regs(input logic [7:0] ptr, output logic [31:0] d, input int n);
		logic b;
		d = 32'h0000_0000;
		start();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(ptr);
		start();
		send_byte({DEV_ADDR, 1'b1});
		for (int k = 0; k < n; k++) begin
			for (int i = 0; i < 8; i++) begin
				get_bit(b);
				d = {d[30:0], b};
			end
			put_bit(k == n - 1);
		end
		stop();
	endtask

	// upper enable byte must be zeroed by the host
	task automatic clear_upper_enable();
		write_regs(8'h00, 32'h0000_0000, 1);
	endtask

	// spurious fault 11 is cleared only after enables are set
	task automatic clear_fault11();
		write_regs(8'h38, 32'h0000_0400, 2);
	endtask

	// recommended period range, 45 us up to 6552+1 steps
	task automatic set_period(input logic [12:0] n);
		logic [12:0] m;
		m = (n > 13'h1998) ? 13'h1998 : n;
		m = (m < 13'h001D) ? 13'h001D : m;
		write_regs(8'h02, {19'h0, m}, 2);
	endtask
endmodule

// ===== bench/led_driver_status_config_regs_tb_top.sv
`timescale 1ns/1ps
module led_driver_status_config_regs_tb_top;
	logic                      clk;
	logic                      rst;
	logic                      scl;
	logic                      host_pull;
	logic                      sda_oe;
	logic                      sda_out;
	logic                      sda_line;
	logic                      startup_active;
	logic                      fault_n;
	logic                      startup_halt;
	logic                      pwm_period_start;
	led_regs_pkg::fault_in_t   fault_in;
	led_regs_pkg::config_out_t cfg_out;
	int                        mismatches = 0;
	int                        compares   = 0;
	int                        cycles     = 0;
	int                        gap;
	logic [31:0]               rd;
	logic [12:0]               per;
	logic [4:0]                code;
	logic [7:0]                en;
	logic [7:0]                v;

	// open-drain wire with pull-up
	assign sda_line = ~(host_pull | (sda_oe & ~sda_out));

	led_driver_status_config_regs #(.DEV_ADDR(7'h2A)) led_driver_status_config_regs_inst (
		.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .fault_in(fault_in), .startup_active(startup_active),
		.cfg_out(cfg_out), .fault_n(fault_n), .startup_halt(startup_halt),
		.pwm_period_start(pwm_period_start)
	);

	serial_host_model #(.DEV_ADDR(7'h2A)) serial_host_model_inst (
		.clk(clk), .sda(sda_line), .scl(scl), .sda_pull(host_pull)
	);

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// on-time ceiling caps at 6553 steps
	function automatic logic [13:0] exp_limit(input logic [12:0] n);
		return ({1'b0, n} + 14'h1 > 14'h1999) ? 14'h1999 : {1'b0, n} + 14'h1;
	endfunction

	task automatic check_cfg(input logic [7:0] e, input logic [12:0] n, input logic [4:0] c);
		check("enable out", cfg_out.string_enable_byte, e);
		check("period out", cfg_out.pwm_period, n);
		check("code out", cfg_out.overvoltage_code, c);
		check("trip volts", cfg_out.overvoltage_volts, 6'h08 + c);
		check("on-time limit", cfg_out.on_time_limit, exp_limit(n));
	endtask

	initial begin
		void'($urandom(32'h57F19550));
		rst            = 1'b1;
		startup_active = 1'b0;
		fault_in       = '0;
		fault_in.drive_ok = 8'hFF;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		check_cfg(8'hFF, 13'h0FFF, 5'h1C);
		serial_host_model_inst.read_regs(8'h00, rd, 3);
		check("enable and period hi reset", rd, 32'h0003FF0F);
		serial_host_model_inst.read_regs(8'h03, rd, 2);
		check("period lo and code reset", rd, 32'h0000FF1C);
		serial_host_model_inst.clear_upper_enable();
		serial_host_model_inst.read_regs(8'h00, rd, 1);
		check("upper enable cleared", rd, 32'h0);
		// random settings plus corners; reserved bits written as ones
		for (int i = 0; i < 8; i++) begin
			en   = 8'($urandom);
			per  = 13'($urandom);
			code = 5'($urandom);
			if (i == 0) begin
				per  = 13'h1998;
				code = 5'h00;
			end
			if (i == 1) begin
				per  = 13'h1FFF;
				code = 5'h1F;
				en   = 8'h00;
			end
			if (i == 2) per = 13'h0000;
			serial_host_model_inst.write_regs(8'h01, {en, 3'b111, per, 3'b111, code}, 4);
			check_cfg(en, per, code);
			serial_host_model_inst.read_regs(8'h01, rd, 4);
			check("settings readback", rd, {en, 3'b000, per, 3'b000, code});
		end
		// live status follows the sense inputs
		v = $urandom;
		@(negedge clk);
		fault_in.ground_short = v;
		fault_in.string_short = ~v;
		serial_host_model_inst.read_regs(8'h35, rd, 3);
		check("live shorts", rd, {8'h00, v, 8'h00, ~v});
		// brief fault events, then quiet inputs
		@(negedge clk);
		fault_in.general         = 12'h400;
		fault_in.regulation_loss = 8'hA5;
		fault_in.drive_ok        = 8'hF0;
		repeat (4) @(negedge clk);
		// quiet inputs in one step, all drives ok
		fault_in = {12'h000, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
		serial_host_model_inst.read_regs(8'h38, rd, 4);
		check("held general and regulation", rd, 32'h040000A5);
		serial_host_model_inst.read_regs(8'h3C, rd, 4);
		check("held shorts", rd, {8'h00, v, 8'h00, ~v});
		serial_host_model_inst.read_regs(8'h41, rd, 3);
		check("drive ok live and held", rd, 32'h00FF000F);
		// write to the live byte is ignored, held byte clears
		serial_host_model_inst.write_regs(8'h41, 32'h000000FF, 3);
		serial_host_model_inst.read_regs(8'h41, rd, 3);
		check("drive ok held cleared", rd, 32'h00FF0000);
		serial_host_model_inst.clear_fault11();
		serial_host_model_inst.write_regs(8'h3B, 32'h05, 1);
		serial_host_model_inst.read_regs(8'h38, rd, 4);
		check("held after clears", rd, 32'h000000A0);
		serial_host_model_inst.write_regs(8'h3C, 32'h00FF00FF, 4);
		serial_host_model_inst.read_regs(8'h3C, rd, 4);
		check("held shorts cleared", rd, 32'h0);
		serial_host_model_inst.read_regs(8'h50, rd, 1);
		check("unmapped reads zero", rd, 32'h0);
		// enabled unpopulated string during startup
		serial_host_model_inst.write_regs(8'h01, 32'h0F, 1);
		@(negedge clk);
		fault_in.unpopulated = 8'hF0;
		startup_active       = 1'b1;
		repeat (3) @(negedge clk);
		check("flag with disabled unpopulated", fault_n, 1'b1);
		fault_in.unpopulated = 8'h18;
		repeat (3) @(negedge clk);
		check("flag with enabled unpopulated", fault_n, 1'b0);
		check("startup halted", startup_halt, 1'b1);
		startup_active       = 1'b0;
		fault_in.unpopulated = 8'h00;
		repeat (2) @(negedge clk);
		check("halt released", startup_halt, 1'b0);
		check("flag released", fault_n, 1'b1);
		// second reset, then shortest recommended period: 30 steps of 300 clk
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		serial_host_model_inst.set_period(13'h001D);
		gap = 0;
		while (!pwm_period_start && gap < 20000) begin
			@(negedge clk);
			gap++;
		end
		@(negedge clk);
		gap = 1;
		while (!pwm_period_start && gap < 20000) begin
			@(negedge clk);
			gap++;
		end
		check("period pulse spacing", gap, 9000);
		check("device acks", serial_host_model_inst.nacks, 32'h0);
		end_of_test();
	end
endmodule
